// ### ssc_pkg.sv
package ssc_pkg;
   // special function register addresses
   localparam logic [7:0] SSC_ADDR_POWER_CONTROL = 8'h87;
   localparam logic [7:0] SSC_ADDR_CLOCK_CONTROL = 8'hD8;
   localparam logic [7:0] SSC_ADDR_FAST_RC_TRIM_WORD = 8'hF6;
   localparam logic [7:0] SSC_ADDR_AUXILIARY_CONTROL_TWO = 8'hF7;

   // clock_control bit positions
   localparam int SSC_CC_SLOW_TYPE = 7;
   localparam int SSC_CC_FAST_TYPE = 6;
   localparam int SSC_CC_SLOW_STOP_PD = 5;
   localparam int SSC_CC_PERIPH_STOP = 4;
   localparam int SSC_CC_FAST_STOP = 3;
   localparam int SSC_CC_FAST_SEL = 2;
   localparam int SSC_CC_PSC_LSB = 0;

   // power_control bit positions
   localparam int SSC_PC_SMOD = 7;
   localparam int SSC_PC_GF1 = 3;
   localparam int SSC_PC_GF0 = 2;
   localparam int SSC_PC_POWER_DOWN = 1;
   localparam int SSC_PC_IDLE = 0;

   // reset values
   localparam logic [7:0] SSC_CLOCK_CONTROL_RST = 8'h23;
   localparam logic [7:0] SSC_AUXILIARY_CONTROL_TWO_RST = 8'h00;
   localparam logic [6:0] SSC_TRIM_RST = 7'h40;

   // prescaler codes and their terminal counts (divide minus one)
   localparam logic [1:0] SSC_PSC_DIV16 = 2'h0;
   localparam logic [1:0] SSC_PSC_DIV4 = 2'h1;
   localparam logic [1:0] SSC_PSC_DIV2 = 2'h2;
   localparam logic [1:0] SSC_PSC_DIV1 = 2'h3;
   localparam logic [3:0] SSC_TERM_DIV16 = 4'hF;
   localparam logic [3:0] SSC_TERM_DIV4 = 4'h3;
   localparam logic [3:0] SSC_TERM_DIV2 = 4'h1;
   localparam logic [3:0] SSC_TERM_DIV1 = 4'h0;

   // nominal oscillator rates in kHz, for reference by users of the block
   localparam real SSC_SLOW_RC_KHZ = 80.0;
   localparam real SSC_FAST_RC_KHZ = 14745.6;

   localparam int SSC_NUM_EXT_PINS = 10;

   typedef enum logic [1:0] {
      SSC_RUN,
      SSC_IDLE,
      SSC_STOP,
      SSC_HALT
   } ssc_mode_e;

   // any external pin held low while its wake enable is set
   function automatic logic ssc_pin_wake(input logic [SSC_NUM_EXT_PINS-1:0] pins,
                                         input logic [SSC_NUM_EXT_PINS-1:0] en);
      ssc_pin_wake = |(~pins & en);
   endfunction : ssc_pin_wake

   function automatic logic [3:0] ssc_psc_term(input logic [1:0] code);
      case (code)
         SSC_PSC_DIV16: ssc_psc_term = SSC_TERM_DIV16;
         SSC_PSC_DIV4: ssc_psc_term = SSC_TERM_DIV4;
         SSC_PSC_DIV2: ssc_psc_term = SSC_TERM_DIV2;
         default: ssc_psc_term = SSC_TERM_DIV1;
      endcase
   endfunction : ssc_psc_term
endpackage : ssc_pkg

// ### ssc_clk_if.sv
`timescale 1ns/10ps
`default_nettype none
interface ssc_clk_if;
   logic src_tick;
   logic [1:0] psc_sel;
   logic sys_tick;
   logic [1:0] psc_active;
   modport div (input src_tick, input psc_sel, output sys_tick, output psc_active);
   modport ctl (output src_tick, output psc_sel, input sys_tick, input psc_active);
endinterface : ssc_clk_if
`default_nettype wire

// ### ssc_prescaler.sv
`timescale 1ns/10ps
`default_nettype none
module ssc_prescaler
   import ssc_pkg::*;
(
   input wire logic ref_clk_i,
   input wire logic srst_i,
   ssc_clk_if.div clk_if
);
   typedef struct packed {
      logic [3:0] count;
      logic [1:0] psc;
   } ssc_div_s;

   ssc_div_s st;
   ssc_div_s next_st;
   logic at_term;

   assign at_term = (st.count == ssc_psc_term(st.psc));
   assign clk_if.sys_tick = clk_if.src_tick & at_term;
   assign clk_if.psc_active = st.psc;

   always_comb begin
      next_st = st;
      if (clk_if.src_tick) begin
         if (at_term) begin
            next_st.count = 4'h0;
            // new setting only at a period boundary, so at most 16 source ticks late
            next_st.psc = clk_if.psc_sel;
         end else begin
            next_st.count = st.count + 4'h1;
         end
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         st <= '{count: 4'h0, psc: SSC_PSC_DIV1};
      end else begin
         st <= next_st;
      end
   end
endmodule : ssc_prescaler
`default_nettype wire

// ### ssc_clock_power.sv
// Notes on behaviour
// - reset runs slow mode from slow RC
// - fast source is crystal or fast RC
// - prescaler codes divide by 16, 4, 2, 1
// - new prescale applies within sixteen clocks
// - slow type changes only in fast mode
// - fast type changes only in slow mode
// - fast stop changes only in slow mode
// - fast select changes only with fast running
// - abnormal clock control writes keep the old protected bits
// - crystal type turns port pins to crystal
// - half system clock drives output pin
// - idle stops CPU, peripherals keep running unless peripheral stop is set
// - peripheral stop gates peripherals in idle
// - power down with slow stop enters stop
// - power down without slow stop enters halt
// - no power down while pin wake pending
// - seven-bit trim steers fast RC frequency
`timescale 1ns/10ps
`default_nettype none
module ssc_clock_power
   import ssc_pkg::*;
#(
   parameter logic [6:0] TRIM_RESET = SSC_TRIM_RST
) (
   input wire logic ref_clk_i,
   input wire logic srst_i,
   input wire logic [7:0] sfr_addr_i,
   input wire logic sfr_wr_i,
   input wire logic sfr_rd_i,
   input wire logic [7:0] sfr_wdata_i,
   output logic [7:0] sfr_rdata_o,
   output logic sfr_hit_o,
   input wire logic fast_crystal_osc_i,
   input wire logic fast_internal_rc_i,
   input wire logic slow_crystal_osc_i,
   input wire logic slow_internal_rc_i,
   input wire logic [SSC_NUM_EXT_PINS-1:0] external_interrupt_pin_i,
   input wire logic [SSC_NUM_EXT_PINS-1:0] external_pin_wake_enable_i,
   input wire logic irq_wake_i,
   input wire logic timer3_wake_i,
   input wire logic clock_output_enable_i,
   output logic cpu_clk_en_o,
   output logic periph_clk_en_o,
   output logic timer3_clk_en_o,
   output logic fast_osc_run_o,
   output logic slow_osc_run_o,
   output logic xtal_pin_mode_o,
   output logic xtal_high_gain_o,
   output logic [6:0] fast_rc_trim_o,
   output logic sysclk_half_out_o,
   output logic sysclk_half_out_oe_o,
   output logic [1:0] power_mode_o
);
   localparam int NSYNC = SSC_NUM_EXT_PINS + 4;

   typedef struct packed {
      logic [NSYNC-1:0] sync1;
      logic [NSYNC-1:0] sync2;
      logic [3:0] osc_prev;
      ssc_mode_e mode;
      logic [7:0] clock_control;
      logic smod;
      logic gf1;
      logic gf0;
      logic [6:0] trim;
      logic [7:0] auxiliary_control_two;
      logic [7:0] rdata;
      logic hit;
      logic half;
      logic half_oe;
   } ssc_state_s;

   ssc_state_s st;
   ssc_state_s next_st;
   ssc_clk_if clk_if ();

   logic [SSC_NUM_EXT_PINS-1:0] pins_s;
   logic [3:0] osc_s;
   logic [3:0] osc_rise;
   logic fast_sel;
   logic fast_type;
   logic slow_type;
   logic fast_stop;
   logic fast_tick;
   logic slow_tick;
   logic pin_wake;
   logic wr_cc;
   logic wr_pc;
   logic [7:0] cc_new;
   logic [7:0] pc_read;
   logic wr_trim;
   logic wr_aux;
   logic pd_req;
   logic idle_req;
   logic wake_now;

   // stop and halt both count as power down for readback and fast oscillator gating
   function automatic logic is_deep(input ssc_mode_e m);
      is_deep = (m == SSC_STOP) || (m == SSC_HALT);
   endfunction : is_deep

   // one decode for every register write strobe, so no write address is matched two ways
   function automatic logic wr_hit(input logic wr,
                                   input logic [7:0] addr,
                                   input logic [7:0] target);
      wr_hit = wr && (addr == target);
   endfunction : wr_hit

   // osc order: fast crystal, fast rc, slow crystal, slow rc
   assign pins_s = st.sync2[NSYNC-1:4];
   assign osc_s = st.sync2[3:0];
   assign osc_rise = osc_s & ~st.osc_prev;

   assign fast_sel = st.clock_control[SSC_CC_FAST_SEL];
   assign fast_type = st.clock_control[SSC_CC_FAST_TYPE];
   assign slow_type = st.clock_control[SSC_CC_SLOW_TYPE];
   assign fast_stop = st.clock_control[SSC_CC_FAST_STOP];

   assign fast_tick = fast_type ? osc_rise[3] : osc_rise[2];
   assign slow_tick = slow_type ? osc_rise[1] : osc_rise[0];
   // a stopped fast oscillator never ticks, so the select is also gated
   assign clk_if.src_tick = (fast_sel && !fast_stop) ? fast_tick : slow_tick;
   assign clk_if.psc_sel = st.clock_control[1:0];

   ssc_prescaler u_prescaler (
      .ref_clk_i(ref_clk_i),
      .srst_i(srst_i),
      .clk_if(clk_if)
   );

   assign pin_wake = ssc_pin_wake(pins_s, external_pin_wake_enable_i);
   assign wr_cc = wr_hit(sfr_wr_i, sfr_addr_i, SSC_ADDR_CLOCK_CONTROL);
   assign wr_pc = wr_hit(sfr_wr_i, sfr_addr_i, SSC_ADDR_POWER_CONTROL);
   assign wr_trim = wr_hit(sfr_wr_i, sfr_addr_i, SSC_ADDR_FAST_RC_TRIM_WORD);
   assign wr_aux = wr_hit(sfr_wr_i, sfr_addr_i, SSC_ADDR_AUXILIARY_CONTROL_TWO);
   // power down outranks idle when one write sets both
   assign pd_req = wr_pc && sfr_wdata_i[SSC_PC_POWER_DOWN];
   assign idle_req = wr_pc && sfr_wdata_i[SSC_PC_IDLE];

   // wake sources differ per sleep mode; run has nothing to wake from
   always_comb begin
      case (st.mode)
         SSC_IDLE: wake_now = irq_wake_i || pin_wake;
         SSC_STOP: wake_now = pin_wake;
         SSC_HALT: wake_now = pin_wake || timer3_wake_i;
         default: wake_now = 1'b0;
      endcase
   end

   // write filter for the protected clock control bits
   always_comb begin
      cc_new = sfr_wdata_i;
      if (!fast_sel) begin
         cc_new[SSC_CC_SLOW_TYPE] = slow_type;
      end
      if (fast_sel) begin
         cc_new[SSC_CC_FAST_TYPE] = fast_type;
         cc_new[SSC_CC_FAST_STOP] = fast_stop;
      end
      if (fast_stop) begin
         cc_new[SSC_CC_FAST_SEL] = fast_sel;
      end
      // stop and select both high would kill the running clock
      if (cc_new[SSC_CC_FAST_STOP] && cc_new[SSC_CC_FAST_SEL]) begin
         cc_new[SSC_CC_SLOW_TYPE] = slow_type;
         cc_new[SSC_CC_FAST_TYPE] = fast_type;
         cc_new[SSC_CC_FAST_STOP] = fast_stop;
         cc_new[SSC_CC_FAST_SEL] = fast_sel;
      end
   end

   always_comb begin
      pc_read = 8'h00;
      pc_read[SSC_PC_SMOD] = st.smod;
      pc_read[SSC_PC_GF1] = st.gf1;
      pc_read[SSC_PC_GF0] = st.gf0;
      pc_read[SSC_PC_POWER_DOWN] = is_deep(st.mode);
      pc_read[SSC_PC_IDLE] = (st.mode == SSC_IDLE);
   end

   always_comb begin
      next_st = st;
      // every pin and oscillator is async to the ref clock: two flops first
      next_st.sync1 = {external_interrupt_pin_i, fast_crystal_osc_i, fast_internal_rc_i,
                       slow_crystal_osc_i, slow_internal_rc_i};
      next_st.sync2 = st.sync1;
      next_st.osc_prev = osc_s;

      if (wr_cc) begin
         next_st.clock_control = cc_new;
      end
      if (wr_trim) begin
         next_st.trim = sfr_wdata_i[6:0];
      end
      if (wr_aux) begin
         next_st.auxiliary_control_two = sfr_wdata_i;
      end
      if (wr_pc) begin
         next_st.smod = sfr_wdata_i[SSC_PC_SMOD];
         next_st.gf1 = sfr_wdata_i[SSC_PC_GF1];
         next_st.gf0 = sfr_wdata_i[SSC_PC_GF0];
      end

      // mode bits are seen as state; waking clears them by leaving the state
      case (st.mode)
         SSC_RUN: begin
            if (pd_req) begin
               if (!pin_wake) begin
                  if (st.clock_control[SSC_CC_SLOW_STOP_PD]) begin
                     next_st.mode = SSC_STOP;
                  end else begin
                     next_st.mode = SSC_HALT;
                  end
               end
            end else if (idle_req) begin
               next_st.mode = SSC_IDLE;
            end
         end
         SSC_IDLE: begin
            if (wake_now) begin
               next_st.mode = SSC_RUN;
            end
         end
         SSC_STOP: begin
            if (wake_now) begin
               next_st.mode = SSC_RUN;
            end
         end
         SSC_HALT: begin
            if (wake_now) begin
               next_st.mode = SSC_RUN;
            end
         end
         default: begin
            next_st.mode = SSC_RUN;
         end
      endcase

      next_st.hit = 1'b0;
      if (sfr_rd_i) begin
         next_st.hit = 1'b1;
         case (sfr_addr_i)
            SSC_ADDR_POWER_CONTROL: next_st.rdata = pc_read;
            SSC_ADDR_CLOCK_CONTROL: next_st.rdata = st.clock_control;
            SSC_ADDR_FAST_RC_TRIM_WORD: next_st.rdata = {1'b0, st.trim};
            SSC_ADDR_AUXILIARY_CONTROL_TWO: next_st.rdata = st.auxiliary_control_two;
            default: begin
               next_st.rdata = 8'h00;
               next_st.hit = 1'b0;
            end
         endcase
      end

      // the half-rate output follows the prescaled system clock in every power mode
      if (clk_if.sys_tick) begin
         next_st.half = !st.half;
      end
      next_st.half_oe = clock_output_enable_i;
   end

   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         st <= '{sync1: '0,
                 sync2: '0,
                 osc_prev: 4'h0,
                 mode: SSC_RUN,
                 clock_control: SSC_CLOCK_CONTROL_RST,
                 smod: 1'b0,
                 gf1: 1'b0,
                 gf0: 1'b0,
                 trim: TRIM_RESET,
                 auxiliary_control_two: SSC_AUXILIARY_CONTROL_TWO_RST,
                 rdata: 8'h00,
                 hit: 1'b0,
                 half: 1'b0,
                 half_oe: 1'b0};
      end else begin
         st <= next_st;
      end
   end

   assign sfr_rdata_o = st.rdata;
   assign sfr_hit_o = st.hit;

   // the selected clock is never touched on wake, so the CPU resumes on it
   assign cpu_clk_en_o = clk_if.sys_tick && (st.mode == SSC_RUN);
   assign periph_clk_en_o = clk_if.sys_tick &&
      ((st.mode == SSC_RUN) ||
       ((st.mode == SSC_IDLE) && !st.clock_control[SSC_CC_PERIPH_STOP]));
   assign timer3_clk_en_o = slow_tick && (st.mode != SSC_STOP);
   assign fast_osc_run_o = !fast_stop && !is_deep(st.mode);
   assign slow_osc_run_o = (st.mode != SSC_STOP);
   assign xtal_pin_mode_o = fast_type || slow_type;
   assign xtal_high_gain_o = fast_type;
   assign fast_rc_trim_o = st.trim;
   assign sysclk_half_out_o = st.half && st.half_oe;
   assign sysclk_half_out_oe_o = st.half_oe;
   assign power_mode_o = st.mode;
endmodule : ssc_clock_power
`default_nettype wire

// ### ssc_osc_model.sv
`timescale 1ns/10ps
`default_nettype none
module ssc_osc_model #(
   parameter int HALF_NS = 32
) (
   output var logic osc_o
);
   // runs free from time zero, so crystals count as settled already
   initial begin
      osc_o = 1'b0;
      forever #(HALF_NS) osc_o = ~osc_o;
   end
endmodule : ssc_osc_model
`default_nettype wire

// ### ssc_clock_power_sva.sv
`timescale 1ns/10ps
`default_nettype none
module ssc_clock_power_sva
   import ssc_pkg::*;
(
   input wire logic ref_clk_i,
   input wire logic srst_i,
   input wire logic [7:0] sfr_addr_i,
   input wire logic sfr_wr_i,
   input wire logic [7:0] sfr_wdata_i,
   input wire logic [SSC_NUM_EXT_PINS-1:0] external_interrupt_pin_i,
   input wire logic [SSC_NUM_EXT_PINS-1:0] external_pin_wake_enable_i,
   input wire logic irq_wake_i,
   input wire logic timer3_wake_i,
   input wire logic cpu_clk_en_o,
   input wire logic periph_clk_en_o,
   input wire logic fast_osc_run_o,
   input wire logic slow_osc_run_o,
   input wire logic xtal_pin_mode_o,
   input wire logic xtal_high_gain_o,
   input wire logic sysclk_half_out_o,
   input wire logic sysclk_half_out_oe_o,
   input wire logic [1:0] power_mode_o
);
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (srst_i);
   chk_reset_slow: assert property ($fell(srst_i) |-> power_mode_o == SSC_RUN
      && !xtal_pin_mode_o && fast_osc_run_o && slow_osc_run_o) else $error("reset state wrong");
   chk_stop_quiet: assert property (power_mode_o == SSC_STOP |-> !(cpu_clk_en_o
      || periph_clk_en_o || fast_osc_run_o || slow_osc_run_o)) else $error("clock alive in stop");
   chk_halt_slow: assert property (power_mode_o == SSC_HALT |-> slow_osc_run_o
      && !fast_osc_run_o && !cpu_clk_en_o && !periph_clk_en_o) else $error("halt clocks wrong");
   chk_idle_cpu: assert property (power_mode_o == SSC_IDLE |-> !cpu_clk_en_o)
      else $error("cpu clocked in idle");
   chk_gain_pins: assert property (xtal_high_gain_o |-> xtal_pin_mode_o)
      else $error("gain without crystal pins");
   chk_half_gate: assert property (!sysclk_half_out_oe_o |-> !sysclk_half_out_o)
      else $error("half clock not gated");
   chk_idle_wake: assert property (power_mode_o == SSC_IDLE && irq_wake_i
      |=> power_mode_o == SSC_RUN) else $error("idle missed wake");
   chk_halt_wake: assert property (power_mode_o == SSC_HALT && timer3_wake_i
      |=> power_mode_o == SSC_RUN) else $error("halt missed timer wake");
   chk_stop_hold: assert property (power_mode_o == SSC_STOP && timer3_wake_i
      && external_pin_wake_enable_i == '0 |=> power_mode_o == SSC_STOP)
      else $error("stop left without pin");
   chk_pd_refuse: assert property ($stable(external_interrupt_pin_i)[*3] ##0 (sfr_wr_i
      && sfr_addr_i == SSC_ADDR_POWER_CONTROL && sfr_wdata_i[1:0] == 2'h2
      && power_mode_o == SSC_RUN && |(~external_interrupt_pin_i & external_pin_wake_enable_i))
      |=> power_mode_o == SSC_RUN) else $error("power down taken with pin low");
endmodule : ssc_clock_power_sva
bind ssc_clock_power ssc_clock_power_sva u_sva (.ref_clk_i, .srst_i, .sfr_addr_i, .sfr_wr_i,
   .sfr_wdata_i, .external_interrupt_pin_i, .external_pin_wake_enable_i, .irq_wake_i,
   .timer3_wake_i, .cpu_clk_en_o, .periph_clk_en_o, .fast_osc_run_o, .slow_osc_run_o,
   .xtal_pin_mode_o, .xtal_high_gain_o, .sysclk_half_out_o, .sysclk_half_out_oe_o, .power_mode_o);
`default_nettype wire

// ### system_clock_power_modes_bench.sv
`timescale 1ns/10ps
`default_nettype none
module system_clock_power_modes_bench
   import ssc_pkg::*;
;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic [7:0] addr = 8'h00;
   logic [7:0] wd = 8'h00;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [9:0] pins = 10'h3FF;
   logic [9:0] wen = 10'h000;
   logic irq = 1'b0;
   logic t3 = 1'b0;
   logic coe = 1'b0;
   logic fx, fr, sx, sr, hit, cpu, per, fo, so, xm, xg, ho, hoe, t3e, hprev;
   logic [7:0] rdata;
   logic [6:0] trim;
   logic [1:0] mode;
   logic [7:0] cur = 8'h23;
   logic [15:0] lfsr = 16'h0037;
   int error_cnt = 0;
   int tests_run = 0;
   int n;
   logic [7:0] tbl [15] = '{8'h23, 8'h63, 8'h67, 8'hE7, 8'hE3, 8'hA3, 8'hA7, 8'h27, 8'h23,
      8'h20, 8'h21, 8'h22, 8'h2B, 8'h2F, 8'h23};

   always #4 clk = ~clk;
   ssc_osc_model #(.HALF_NS(24)) u_fx (.osc_o(fx));
   ssc_osc_model #(.HALF_NS(16)) u_fr (.osc_o(fr));
   ssc_osc_model #(.HALF_NS(40)) u_sx (.osc_o(sx));
   ssc_osc_model #(.HALF_NS(32)) u_sr (.osc_o(sr));
   ssc_clock_power u_dut (.ref_clk_i(clk), .srst_i(srst), .sfr_addr_i(addr), .sfr_wr_i(wr),
      .sfr_rd_i(rd), .sfr_wdata_i(wd), .sfr_rdata_o(rdata), .sfr_hit_o(hit),
      .fast_crystal_osc_i(fx), .fast_internal_rc_i(fr), .slow_crystal_osc_i(sx),
      .slow_internal_rc_i(sr), .external_interrupt_pin_i(pins), .external_pin_wake_enable_i(wen),
      .irq_wake_i(irq), .timer3_wake_i(t3), .clock_output_enable_i(coe), .cpu_clk_en_o(cpu),
      .periph_clk_en_o(per), .timer3_clk_en_o(t3e), .fast_osc_run_o(fo), .slow_osc_run_o(so),
      .xtal_pin_mode_o(xm), .xtal_high_gain_o(xg), .fast_rc_trim_o(trim),
      .sysclk_half_out_o(ho), .sysclk_half_out_oe_o(hoe), .power_mode_o(mode));

   function automatic logic [15:0] lfsr_next(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : lfsr_next

   function automatic logic [7:0] exp_d8(input logic [7:0] o, input logic [7:0] w);
      logic [7:0] r;
      r = w;
      if (!o[2]) r[7] = o[7];
      if (o[2]) r[6] = o[6];
      if (o[2]) r[3] = o[3];
      if (o[3]) r[2] = o[2];
      if (r[3] & r[2]) {r[7], r[6], r[3], r[2]} = {o[7], o[6], o[3], o[2]};
      return r;
   endfunction : exp_d8

   // source period in ref cycles times the divide ratio
   function automatic int per_of(input logic [7:0] d);
      int src;
      src = d[2] ? (d[6] ? 6 : 4) : (d[7] ? 10 : 8);
      return src * (d[1:0] == 2'h0 ? 16 : d[1:0] == 2'h1 ? 4 : d[1:0] == 2'h2 ? 2 : 1);
   endfunction : per_of

   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : wrap_up

   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED t=%0t seen=%h expected=%h", $time, got, exp);
      end
   endtask : check

   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wd <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wr_reg

   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      check(rdata, e);
      check(8'(hit), 8'(a inside {8'h87, 8'hD8, 8'hF6, 8'hF7}));
   endtask : rd_chk

   task automatic gap_chk(input int e);
      int k;
      k = 0;
      do begin @(negedge clk); k++; end while (cpu !== 1'b1 && k < 400);
      k = 0;
      do begin @(negedge clk); k++; end while (cpu !== 1'b1 && k < 400);
      check(8'(k), 8'(e));
   endtask : gap_chk

   task automatic set_d8(input logic [7:0] v);
      cur = exp_d8(cur, v);
      wr_reg(SSC_ADDR_CLOCK_CONTROL, v);
      rd_chk(SSC_ADDR_CLOCK_CONTROL, cur);
      check(8'({xm, xg, fo}), 8'({cur[7] | cur[6], cur[6], !cur[3]}));
      // sixteen ticks of the newly selected source under the old ratio at worst before the new ratio holds
      repeat (168) @(negedge clk);
      gap_chk(per_of(cur));
   endtask : set_d8

   task automatic cnt_chk(input int e, input int e3);
      int k;
      int k3;
      k = 0;
      k3 = 0;
      repeat (64) begin @(negedge clk); if (per === 1'b1) k++; if (t3e === 1'b1) k3++; end
      check(8'(k), 8'(e));
      check(8'(k3), 8'(e3));
      @(posedge clk);
   endtask : cnt_chk

   task automatic mode_chk(input logic [1:0] e);
      @(negedge clk);
      check(8'(mode), 8'(e));
      @(posedge clk);
   endtask : mode_chk

   initial begin
      #(8 * 80000);
      error_cnt++;
      wrap_up();
   end

   initial begin
      repeat (6) @(posedge clk);
      srst <= 1'b0;
      repeat (4) rd_chk(SSC_ADDR_POWER_CONTROL, 8'h00);
      rd_chk(SSC_ADDR_CLOCK_CONTROL, SSC_CLOCK_CONTROL_RST);
      rd_chk(SSC_ADDR_FAST_RC_TRIM_WORD, 8'h40);
      rd_chk(SSC_ADDR_AUXILIARY_CONTROL_TWO, 8'h00);
      rd_chk(8'h80, 8'h00);
      gap_chk(8);
      for (int i = 0; i < 4; i++) begin
         lfsr = lfsr_next(lfsr);
         wr_reg(SSC_ADDR_FAST_RC_TRIM_WORD, lfsr[7:0]);
         rd_chk(SSC_ADDR_FAST_RC_TRIM_WORD, {1'b0, lfsr[6:0]});
         check(8'(trim), 8'(lfsr[6:0]));
         wr_reg(SSC_ADDR_AUXILIARY_CONTROL_TWO, lfsr[15:8]);
         rd_chk(SSC_ADDR_AUXILIARY_CONTROL_TWO, lfsr[15:8]);
      end
      // crystal settled and prescale delay kept before each fast switch
      foreach (tbl[i]) set_d8(tbl[i]);
      for (int i = 0; i < 10; i++) begin
         lfsr = lfsr_next(lfsr);
         set_d8(lfsr[7:0]);
      end
      @(posedge clk);
      srst <= 1'b1;
      repeat (6) @(posedge clk);
      srst <= 1'b0;
      cur = 8'h23;
      rd_chk(SSC_ADDR_CLOCK_CONTROL, 8'h23);
      @(posedge clk);
      coe <= 1'b1;
      repeat (4) @(posedge clk);
      n = 0;
      @(negedge clk);
      hprev = ho;
      repeat (64) begin @(negedge clk); if (ho !== hprev) n++; hprev = ho; end
      check(8'(n), 8'h08);
      check(8'(hoe), 8'h01);
      wr_reg(SSC_ADDR_CLOCK_CONTROL, 8'h33);
      wr_reg(SSC_ADDR_POWER_CONTROL, 8'h01);
      mode_chk(SSC_IDLE);
      cnt_chk(0, 8);
      rd_chk(SSC_ADDR_POWER_CONTROL, 8'h01);
      @(posedge clk);
      irq <= 1'b1;
      @(posedge clk);
      irq <= 1'b0;
      mode_chk(SSC_RUN);
      rd_chk(SSC_ADDR_POWER_CONTROL, 8'h00);
      wr_reg(SSC_ADDR_CLOCK_CONTROL, 8'h23);
      wr_reg(SSC_ADDR_POWER_CONTROL, 8'h01);
      cnt_chk(8, 8);
      // slow clock stays selected before every power down
      wr_reg(SSC_ADDR_POWER_CONTROL, 8'h00);
      irq <= 1'b1;
      @(posedge clk);
      irq <= 1'b0;
      wr_reg(SSC_ADDR_POWER_CONTROL, 8'h02);
      mode_chk(SSC_STOP);
      cnt_chk(0, 0);
      t3 <= 1'b1;
      repeat (5) @(posedge clk);
      mode_chk(SSC_STOP);
      wen <= 10'h001;
      pins <= 10'h3FE;
      repeat (5) @(posedge clk);
      mode_chk(SSC_RUN);
      t3 <= 1'b0;
      wr_reg(SSC_ADDR_POWER_CONTROL, 8'h02);
      mode_chk(SSC_RUN);
      wen <= 10'h000;
      pins <= 10'h3FF;
      wr_reg(SSC_ADDR_CLOCK_CONTROL, 8'h03);
      wr_reg(SSC_ADDR_POWER_CONTROL, 8'h02);
      mode_chk(SSC_HALT);
      cnt_chk(0, 8);
      t3 <= 1'b1;
      @(posedge clk);
      t3 <= 1'b0;
      mode_chk(SSC_RUN);
      wrap_up();
   end
endmodule : system_clock_power_modes_bench
`default_nettype wire
